// file: verilog/ofm_defs.svh
`ifndef OFM_DEFS_SVH
`define OFM_DEFS_SVH
`define OFM_CLK_HZ 100000000
`define OFM_WIN_MS_DEF 100
`define OFM_RST_WIN_MS 5000
`define OFM_BLINK_MS 250
`define OFM_MS_CYC (`OFM_CLK_HZ / 1000)
`define OFM_MAX_INST 32
`endif

// file: verilog/ofm_pkg.sv
`include "ofm_defs.svh"
package ofm_pkg;
	typedef enum logic [3:0] {
		RD_IDLE = 4'h1,
		RD_HIGH1 = 4'h2,
		RD_LOW1 = 4'h4,
		RD_HIGH2 = 4'h8
	} ofm_rd_state_t;
endpackage

// file: verilog/ofm_output_feedback_monitor.sv
`include "ofm_defs.svh"
// What this block does
// - feedback must be inverse of output after window
// - mismatch forces monitored output low
// - fault flashes the output's fault LED
// - error flag high on fault when enabled
// - clear input only acts when enabled
// - clear high removes repaired latched fault
// - feedback window is a configurable parameter
// - up to thirty-two instances
// - two off-on-off pulses under 5 s reset
// - sequence over 5 s gives no reset
// - generated reset clears latched faults unless the window check still sees wrong feedback
module ofm_output_feedback_monitor
	import ofm_pkg::*;
#(
	parameter int WIN_MS = `OFM_WIN_MS_DEF,
	parameter int MS_CYC = `OFM_MS_CYC,
	parameter int RST_WIN_MS = `OFM_RST_WIN_MS,
	parameter int BLINK_MS = `OFM_BLINK_MS,
	parameter int INSTANCES = 1
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic REQ_OUT,
	input wire logic FBK,
	input wire logic CLEAR_EN,
	input wire logic CLEAR,
	input wire logic ERR_OUT_EN,
	input wire logic RESET_IN,
	output logic SAFE_OUT,
	output logic FAULT_LED,
	output logic ERROR_OUT,
	output logic SYS_RESET
);
	// ************************************************
	// reset and input synchronisers
	// ************************************************
	logic rst_s1, rst_n_i;
	logic [1:0] fbk_s, clr_s, rin_s;
	logic fbk, clr, rin, rin_d;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_s1 <= 1'b0;
			rst_n_i <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n_i <= rst_s1;
		end
	end
	always_ff @(posedge SYS_CLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fbk_s <= 2'h0;
			clr_s <= 2'h0;
			rin_s <= 2'h0;
			rin_d <= 1'b0;
		end else begin
			fbk_s <= {fbk_s[0], FBK};
			clr_s <= {clr_s[0], CLEAR};
			rin_s <= {rin_s[0], RESET_IN};
			rin_d <= rin_s[1];
		end
	end
	assign fbk = fbk_s[1];
	assign clr = clr_s[1];
	assign rin = rin_s[1];

	// ************************************************
	// counter helpers
	// ************************************************
	localparam logic [31:0] WIN_CYC = 32'(WIN_MS * MS_CYC);
	localparam logic [31:0] RST_CYC = 32'(RST_WIN_MS * MS_CYC);
	// counter has arrived at its end count
	function automatic logic reached(input logic [31:0] value, input logic [31:0] limit);
		reached = (value >= limit);
	endfunction
	// one step of an up-counter that stops at its end count
	function automatic logic [31:0] count_up(input logic [31:0] value, input logic [31:0] limit);
		count_up = reached(value, limit) ? limit : value + 32'h1;
	endfunction

	// ************************************************
	// millisecond tick
	// ************************************************
	logic [31:0] ms_cnt, next_ms_cnt;
	logic ms_tick;
	always_comb begin
		ms_tick = (ms_cnt == 32'(MS_CYC - 1));
		next_ms_cnt = ms_tick ? 32'h0 : ms_cnt + 32'h1;
	end
	always_ff @(posedge SYS_CLK or negedge rst_n_i) begin
		if (!rst_n_i) ms_cnt <= 32'h0;
		else ms_cnt <= next_ms_cnt;
	end

	// ************************************************
	// reset detector
	// ************************************************
	ofm_rd_state_t rd_state, next_rd_state;
	logic [31:0] rd_cnt, next_rd_cnt;
	logic next_sys_reset;
	logic rin_rise, rin_fall, rd_tmo;
	always_comb begin
		rin_rise = rin & ~rin_d;
		rin_fall = ~rin & rin_d;
		rd_tmo = reached(rd_cnt, RST_CYC);
		next_rd_state = rd_state;
		next_rd_cnt = count_up(rd_cnt, RST_CYC);
		next_sys_reset = 1'b0;
		case (rd_state)
			RD_IDLE: begin
				if (rin_rise) begin
					next_rd_state = RD_HIGH1;
					next_rd_cnt = 32'h0;
				end
			end
			RD_HIGH1: begin
				if (rd_tmo) next_rd_state = RD_IDLE;
				else if (rin_fall) next_rd_state = RD_LOW1;
			end
			RD_LOW1: begin
				if (rd_tmo) next_rd_state = RD_IDLE;
				else if (rin_rise) next_rd_state = RD_HIGH2;
			end
			RD_HIGH2: begin
				if (rd_tmo) next_rd_state = RD_IDLE;
				else if (rin_fall) begin
					next_rd_state = RD_IDLE;
					next_sys_reset = 1'b1;
				end
			end
			default: next_rd_state = RD_IDLE;
		endcase
	end
	always_ff @(posedge SYS_CLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_state <= RD_IDLE;
			rd_cnt <= 32'h0;
			SYS_RESET <= 1'b0;
		end else begin
			rd_state <= next_rd_state;
			rd_cnt <= next_rd_cnt;
			SYS_RESET <= next_sys_reset;
		end
	end

	// ************************************************
	// fault indicator blink
	// ************************************************
	logic [31:0] blink_ms, next_blink_ms;
	logic blink, next_blink;
	always_comb begin
		next_blink_ms = blink_ms;
		next_blink = blink;
		if (ms_tick) begin
			if (reached(blink_ms + 32'h1, 32'(BLINK_MS))) begin
				next_blink_ms = 32'h0;
				next_blink = ~blink;
			end else begin
				next_blink_ms = blink_ms + 32'h1;
			end
		end
	end
	always_ff @(posedge SYS_CLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			blink_ms <= 32'h0;
			blink <= 1'b0;
		end else begin
			blink_ms <= next_blink_ms;
			blink <= next_blink;
		end
	end

	// ************************************************
	// feedback window check
	// ************************************************
	logic req_d, fault, win_done;
	logic next_req_d, next_fault, next_win_done;
	logic [31:0] win_cnt, next_win_cnt;
	logic fbk_wrong, clear_ok;
	logic next_safe_out, next_fault_led, next_error_out;
	always_comb begin
		next_req_d = REQ_OUT;
		next_win_cnt = win_cnt;
		next_win_done = win_done;
		if (REQ_OUT != req_d) begin
			next_win_cnt = 32'h0;
			next_win_done = 1'b0;
		end else if (!win_done) begin
			next_win_cnt = count_up(win_cnt, WIN_CYC);
			next_win_done = reached(next_win_cnt, WIN_CYC);
		end
		fbk_wrong = win_done && (REQ_OUT == req_d) && (fbk == req_d);
		clear_ok = CLEAR_EN && clr && (fbk != REQ_OUT);
		next_fault = fault;
		if (SYS_RESET) next_fault = 1'b0;
		else if (clear_ok) next_fault = 1'b0;
		if (fbk_wrong) next_fault = 1'b1;
		next_safe_out = REQ_OUT & ~next_fault;
		next_fault_led = next_fault & next_blink;
		next_error_out = next_fault & ERR_OUT_EN;
	end
	always_ff @(posedge SYS_CLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_d <= 1'b0;
			win_cnt <= 32'h0;
			win_done <= 1'b0;
			fault <= 1'b0;
			SAFE_OUT <= 1'b0;
			FAULT_LED <= 1'b0;
			ERROR_OUT <= 1'b0;
		end else begin
			req_d <= next_req_d;
			win_cnt <= next_win_cnt;
			win_done <= next_win_done;
			fault <= next_fault;
			SAFE_OUT <= next_safe_out;
			FAULT_LED <= next_fault_led;
			ERROR_OUT <= next_error_out;
		end
	end

	// ************************************************
	// assertions
	// ************************************************
	initial begin
		if (INSTANCES > `OFM_MAX_INST) $error("too many monitor instances");
	end
	property p_out_low_on_fault;
		@(posedge SYS_CLK) disable iff (!rst_n_i) fault |-> !SAFE_OUT;
	endproperty
	a_out_low_on_fault: assert property (p_out_low_on_fault) else $error("output high in fault");
	property p_err_flag;
		@(posedge SYS_CLK) disable iff (!rst_n_i) ERROR_OUT == (fault && $past(ERR_OUT_EN));
	endproperty
	a_err_flag: assert property (p_err_flag) else $error("error flag mismatch");
	property p_led_dark;
		@(posedge SYS_CLK) disable iff (!rst_n_i) !fault |-> !FAULT_LED;
	endproperty
	a_led_dark: assert property (p_led_dark) else $error("led lit without fault");
	property p_detect;
		@(posedge SYS_CLK) disable iff (!rst_n_i)
			(win_done && REQ_OUT == req_d && fbk == req_d && !fault) |=> fault;
	endproperty
	a_detect: assert property (p_detect) else $error("feedback fault missed");
	property p_restart;
		@(posedge SYS_CLK) disable iff (!rst_n_i) (REQ_OUT != req_d) |=> (win_cnt == 32'h0 && !win_done);
	endproperty
	a_restart: assert property (p_restart) else $error("window not restarted");
	property p_no_clear_disabled;
		@(posedge SYS_CLK) disable iff (!rst_n_i) (fault && !CLEAR_EN && !SYS_RESET) |=> fault;
	endproperty
	a_no_clear_disabled: assert property (p_no_clear_disabled) else $error("cleared while disabled");
	property p_sysrst_clears;
		@(posedge SYS_CLK) disable iff (!rst_n_i)
			(SYS_RESET && !(win_done && REQ_OUT == req_d && fbk == req_d)) |=> !fault;
	endproperty
	a_sysrst_clears: assert property (p_sysrst_clears) else $error("reset left fault");
	property p_reset_in_time;
		@(posedge SYS_CLK) disable iff (!rst_n_i) next_sys_reset |-> !rd_tmo;
	endproperty
	a_reset_in_time: assert property (p_reset_in_time) else $error("late reset issued");
	property p_reset_pulse;
		@(posedge SYS_CLK) disable iff (!rst_n_i) SYS_RESET |=> !SYS_RESET;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("reset not one pulse");
	property p_clear;
		@(posedge SYS_CLK) disable iff (!rst_n_i) (fault && clear_ok && !fbk_wrong) |=> !fault;
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");
	property p_no_early;
		@(posedge SYS_CLK) disable iff (!rst_n_i) (!fault && !win_done) |=> !fault;
	endproperty
	a_no_early: assert property (p_no_early) else $error("fault inside window");
	property p_win_len;
		@(posedge SYS_CLK) disable iff (!rst_n_i) win_done |-> (win_cnt == WIN_CYC);
	endproperty
	a_win_len: assert property (p_win_len) else $error("window length wrong");
	property p_rd_start;
		@(posedge SYS_CLK) disable iff (!rst_n_i)
			(rd_state == RD_IDLE && rin_rise) |=> (rd_state == RD_HIGH1 && rd_cnt == 32'h0);
	endproperty
	a_rd_start: assert property (p_rd_start) else $error("timer not started");
	property p_rd_abandon;
		@(posedge SYS_CLK) disable iff (!rst_n_i)
			(rd_state != RD_IDLE && rd_tmo) |=> (rd_state == RD_IDLE && !SYS_RESET);
	endproperty
	a_rd_abandon: assert property (p_rd_abandon) else $error("late sequence kept");
	property p_safe_follows;
		@(posedge SYS_CLK) disable iff (!rst_n_i) SAFE_OUT == ($past(REQ_OUT) && !fault);
	endproperty
	a_safe_follows: assert property (p_safe_follows) else $error("output state wrong");

	// ************************************************
	// cover points
	// ************************************************
	c_fault: cover property (@(posedge SYS_CLK) disable iff (!rst_n_i) $rose(fault));
	c_led: cover property (@(posedge SYS_CLK) disable iff (!rst_n_i) $rose(FAULT_LED));
	c_clear: cover property (@(posedge SYS_CLK) disable iff (!rst_n_i) $fell(fault) && CLEAR_EN);
	c_sysrst: cover property (@(posedge SYS_CLK) disable iff (!rst_n_i) SYS_RESET);
	c_timeout: cover property (@(posedge SYS_CLK) disable iff (!rst_n_i)
		rd_state == RD_HIGH2 && rd_tmo);
endmodule

// file: testbench/ofm_contactor.sv
module ofm_contactor (
	input wire logic clk,
	input wire logic coil,
	input wire logic stuck,
	output logic fbk
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] dly;
	// ****
	// contact reports inverted coil late, or stays open when stuck
	// ****
	always @(posedge clk) begin
		dly <= {dly[1:0], ~coil};
	end
	assign fbk = stuck ? 1'b1 : dly[2];
endmodule

// file: testbench/ofm_tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MSC = 10;
	localparam int WMS = 2;
	localparam int RWMS = 20;
	logic SYS_CLK, RST_N, REQ_OUT, FBK, CLEAR_EN, CLEAR, ERR_OUT_EN, RESET_IN, stuck, l;
	logic SAFE_OUT, FAULT_LED, ERROR_OUT, SYS_RESET;
	int n_errors, num_checks, i, e, seen, exp_n;
	ofm_output_feedback_monitor #(.WIN_MS(WMS), .MS_CYC(MSC), .RST_WIN_MS(RWMS),
		.BLINK_MS(2)) uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REQ_OUT(REQ_OUT),
		.FBK(FBK), .CLEAR_EN(CLEAR_EN), .CLEAR(CLEAR), .ERR_OUT_EN(ERR_OUT_EN),
		.RESET_IN(RESET_IN), .SAFE_OUT(SAFE_OUT), .FAULT_LED(FAULT_LED),
		.ERROR_OUT(ERROR_OUT), .SYS_RESET(SYS_RESET));
	ofm_contactor k (.clk(SYS_CLK), .coil(SAFE_OUT), .stuck(stuck), .fbk(FBK));
	// ****
	// helpers
	// ****
	task automatic cyc(input int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask
	task automatic chk(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_n(input int got, input int exp);
		num_checks++;
		if (got != exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// resets expected from a double pulse of width w cycles
	function automatic int exp_resets(input int w);
		return (3 * w < RWMS * MSC) ? 1 : 0;
	endfunction
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// double off-on-off pulse of width w, counts reset pulses
	task automatic pulses(input int w);
		seen = 0;
		exp_n = exp_resets(w);
		for (i = 0; i < 5; i++) begin
			if (i < 4)
				RESET_IN = ~RESET_IN;
			repeat (w) begin
				cyc(1);
				if (SYS_RESET === 1'b1)
					seen++;
			end
		end
		$display("pulse test w=%0d done", w);
	endtask
	// ****
	// stimulus
	// ****
	initial begin
		SYS_CLK = 0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end
	initial begin
		#100us;
		n_errors++;
		end_of_test();
	end
	initial begin
		{RST_N, REQ_OUT, CLEAR_EN, CLEAR, ERR_OUT_EN, RESET_IN, stuck} = 7'h00;
		n_errors = 0;
		num_checks = 0;
		void'($urandom(32'hBCDDE833));
		cyc(8);
		RST_N = 1;
		cyc(4);
		for (e = 0; e < 2; e++) begin
			ERR_OUT_EN = e[0];
			REQ_OUT = 1;
			cyc(3 * MSC * WMS);
			chk(SAFE_OUT, 1);
			chk(ERROR_OUT, 0);
			REQ_OUT = 0;
			cyc(3 * MSC * WMS);
			stuck = 1;
			REQ_OUT = 1;
			cyc(MSC * WMS - 4);
			chk(SAFE_OUT, 1);
			cyc(10);
			chk(SAFE_OUT, 0);
			chk(ERROR_OUT, e[0]);
			seen = 0;
			l = FAULT_LED;
			repeat (12 * MSC) begin
				cyc(1);
				if (FAULT_LED !== l)
					seen++;
				l = FAULT_LED;
			end
			chk(seen >= 4, 1);
			stuck = 0;
			REQ_OUT = 0;
			ERR_OUT_EN = 1;
			cyc(5);
			CLEAR = 1;
			cyc(10);
			chk(ERROR_OUT, 1);
			if (e) begin
				CLEAR_EN = 1;
				cyc(10);
				chk(ERROR_OUT, 0);
			end else begin
				CLEAR = 0;
				pulses(10 + $urandom % 30);
				chk_n(seen, exp_n);
				chk(ERROR_OUT, 0);
			end
			CLEAR = 0;
			CLEAR_EN = 0;
			chk(FAULT_LED, 0);
			$display("fault test %0d done", e);
		end
		pulses(70 + $urandom % 20);
		chk_n(seen, exp_n);
		pulses(10 + $urandom % 30);
		chk_n(seen, exp_n);
		end_of_test();
	end
endmodule
